// file: logic/block_queue_pkg.sv
// Package with the shared constants and types of the block queue link.
`default_nettype none
package block_queue_pkg;
	localparam int NUM_CPU     = 4;
	localparam int NUM_FIELDS  = 48;
	localparam int FIELD_WORDS = 32;
	localparam int NUM_CONN    = NUM_CPU * NUM_CPU;
	localparam int FIELD_W     = 6;
	localparam int WORD_W      = 5;
	localparam int CNT_W       = 6;
	localparam int CPU_W       = 3;
	localparam int CONN_W      = 4;
	localparam logic [CPU_W-1:0] CPU_FIRST = 3'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO  = 6'h00;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_INIT,
		OP_SEND,
		OP_SEND_TEST,
		OP_RECV,
		OP_RECV_TEST
	} op_t;

	typedef enum logic [1:0] {
		ST_OK,
		ST_WARN,
		ST_ERR
	} status_t;
endpackage : block_queue_pkg
`default_nettype wire

// file: logic/block_queue_if.sv
// Interface joining the processor end and the shared buffer end.
`timescale 1ns/1ps
`default_nettype none
interface block_queue_if;
	import block_queue_pkg::*;
	logic                    req;
	op_t                     op;
	logic [CPU_W-1:0]        own_cpu;
	logic [CPU_W-1:0]        peer_cpu;
	logic [CNT_W-1:0]        init_count [NUM_CONN];
	logic [WORD_W-1:0]       first_word;
	logic [WORD_W:0]         length;
	logic [15:0]             block_id;
	logic [15:0]             wr_data;
	logic                    wr_valid;
	logic                    busy;
	logic                    done;
	status_t                 status;
	logic [CNT_W-1:0]        capacity;
	logic [15:0]             rd_block_id;
	logic [WORD_W-1:0]       rd_first_word;
	logic [WORD_W:0]         rd_length;
	logic [15:0]             rd_data;
	logic                    rd_valid;
	logic                    ready;

	modport buffer (input req, op, own_cpu, peer_cpu, init_count, first_word,
		length, block_id, wr_data, wr_valid,
		output busy, done, status, capacity, rd_block_id, rd_first_word,
		rd_length, rd_data, rd_valid, ready);
	modport cpu (output req, op, own_cpu, peer_cpu, init_count, first_word,
		length, block_id, wr_data, wr_valid,
		input busy, done, status, capacity, rd_block_id, rd_first_word,
		rd_length, rd_data, rd_valid, ready);
endinterface : block_queue_if
`default_nettype wire

// file: logic/block_queue_buffer.sv
// Shared buffer end: storage fields handed out to directed connections.
`timescale 1ns/1ps
`default_nettype none
module block_queue_buffer (
	input  wire logic  mclk,
	input  wire logic  rst_n,
	block_queue_if.buffer bus
);
	import block_queue_pkg::*;

	// -------------------------------------------------------------
	// Storage and per-connection queue state
	// -------------------------------------------------------------
	// Storage sits outside the reset so it rides through power loss.
	logic [15:0]        mem_q [NUM_FIELDS][FIELD_WORDS];
	logic [15:0]        fid_q [NUM_FIELDS];
	logic [WORD_W-1:0]  ffw_q [NUM_FIELDS];
	logic [WORD_W:0]    flen_q [NUM_FIELDS];
	logic [FIELD_W-1:0] base_q [NUM_CONN];
	logic [CNT_W-1:0]   resv_q [NUM_CONN];
	logic [CNT_W-1:0]   head_q [NUM_CONN];
	logic [CNT_W-1:0]   occ_q  [NUM_CONN];
	logic               init_ok_q;

	typedef enum logic [1:0] {S_IDLE, S_WRITE, S_READ} fsm_t;
	fsm_t               st_q;
	logic [CONN_W-1:0]  conn_q;
	logic [FIELD_W-1:0] fld_q;
	logic [WORD_W:0]    cnt_q;
	logic [CONN_W-1:0]  conn_d;

	// Connection index from transmitter and receiver, both counted from one.
	function automatic logic [CONN_W-1:0] conn_of(input logic [CPU_W-1:0] tx,
		input logic [CPU_W-1:0] rx);
		logic [CPU_W-1:0] t;
		logic [CPU_W-1:0] r;
		t = tx - CPU_FIRST;
		r = rx - CPU_FIRST;
		conn_of = {t[1:0], r[1:0]};
	endfunction : conn_of

	// Field number of a slot within a connection ring.
	function automatic logic [FIELD_W-1:0] slot(input logic [CONN_W-1:0] c,
		input logic [CNT_W-1:0] off);
		logic [CNT_W:0] s;
		s = {1'b0, head_q[c]} + {1'b0, off};
		if (s >= {1'b0, resv_q[c]}) begin
			s = s - {1'b0, resv_q[c]};
		end
		slot = FIELD_W'(base_q[c] + FIELD_W'(s));
	endfunction : slot

	// Sender enqueues toward peer, receiver dequeues from peer.
	always_comb begin
		if (bus.op == OP_SEND || bus.op == OP_SEND_TEST) begin
			conn_d = conn_of(bus.own_cpu, bus.peer_cpu);
		end else begin
			conn_d = conn_of(bus.peer_cpu, bus.own_cpu);
		end
	end

	// -------------------------------------------------------------
	// Command sequencer
	// -------------------------------------------------------------
	// Only the sequencer is reset; queue state is kept for warm restart.
	always_ff @(posedge mclk) begin
		bus.done     <= 1'b0;
		bus.rd_valid <= 1'b0;
		if (!rst_n) begin
			st_q          <= S_IDLE;
			bus.busy      <= 1'b0;
			bus.status    <= ST_OK;
			bus.capacity  <= CNT_ZERO;
			bus.rd_data   <= 16'h0000;
			bus.rd_block_id   <= 16'h0000;
			bus.rd_first_word <= '0;
			bus.rd_length     <= '0;
			bus.ready     <= 1'b0;
			conn_q        <= '0;
			fld_q         <= '0;
			cnt_q         <= '0;
		end else begin
			bus.ready <= init_ok_q;
			case (st_q)
				S_IDLE: begin
					if (bus.req) begin
						conn_q <= conn_d;
						bus.done <= 1'b1;
						bus.status <= ST_OK;
						case (bus.op)
							OP_INIT: begin
								bus.capacity <= CNT_ZERO;
							end
							OP_SEND, OP_SEND_TEST: begin
								bus.capacity <= resv_q[conn_d] - occ_q[conn_d];
								if (bus.op == OP_SEND) begin
									if (occ_q[conn_d] == resv_q[conn_d]) begin
										bus.status <= ST_WARN;
									end else if (bus.length == '0 ||
										bus.length > (WORD_W+1)'(FIELD_WORDS)) begin
										bus.status <= ST_ERR;
									end else begin
										bus.done <= 1'b0;
										bus.busy <= 1'b1;
										st_q <= S_WRITE;
										fld_q <= slot(conn_d, occ_q[conn_d]);
										cnt_q <= '0;
										// Answer fields wait for the closing done.
										bus.status   <= bus.status;
										bus.capacity <= bus.capacity;
									end
								end
							end
							OP_RECV, OP_RECV_TEST: begin
								bus.capacity <= occ_q[conn_d];
								if (bus.op == OP_RECV) begin
									if (occ_q[conn_d] == CNT_ZERO) begin
										bus.status <= ST_WARN;
									end else begin
										bus.done <= 1'b0;
										bus.busy <= 1'b1;
										st_q <= S_READ;
										fld_q <= slot(conn_d, CNT_ZERO);
										cnt_q <= '0;
										bus.status   <= bus.status;
										bus.capacity <= bus.capacity;
									end
								end
							end
							default: begin
								bus.done <= 1'b0;
							end
						endcase
					end
				end
				S_WRITE: begin
					if (bus.wr_valid) begin
						cnt_q <= cnt_q + 6'h01;
						if (cnt_q + 6'h01 == flen_q[fld_q]) begin
							st_q <= S_IDLE;
							bus.busy <= 1'b0;
							bus.done <= 1'b1;
							bus.status <= ST_OK;
							bus.capacity <= resv_q[conn_q] -
								occ_q[conn_q] - 6'h01;
						end
					end
				end
				S_READ: begin
					// Words return at the sender's own addresses.
					bus.rd_block_id   <= fid_q[fld_q];
					bus.rd_first_word <= ffw_q[fld_q];
					bus.rd_length     <= flen_q[fld_q];
					bus.rd_data  <= mem_q[fld_q][ffw_q[fld_q] + cnt_q[WORD_W-1:0]];
					bus.rd_valid <= 1'b1;
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q + 6'h01 == flen_q[fld_q]) begin
						st_q <= S_IDLE;
						bus.busy <= 1'b0;
						bus.done <= 1'b1;
						bus.status <= ST_OK;
						bus.capacity <= occ_q[conn_q] - 6'h01;
					end
				end
				default: begin
					st_q <= S_IDLE;
				end
			endcase
		end
	end

	// Field contents: header taken at acceptance, words as they stream in.
	always_ff @(posedge mclk) begin
		if (st_q == S_IDLE && bus.req && bus.op == OP_SEND && rst_n &&
			occ_q[conn_d] != resv_q[conn_d]) begin
			fid_q[slot(conn_d, occ_q[conn_d])]  <= bus.block_id;
			ffw_q[slot(conn_d, occ_q[conn_d])]  <= bus.first_word;
			flen_q[slot(conn_d, occ_q[conn_d])] <= bus.length;
		end
		if (st_q == S_WRITE && bus.wr_valid && rst_n) begin
			mem_q[fld_q][ffw_q[fld_q] + cnt_q[WORD_W-1:0]] <= bus.wr_data;
		end
	end

	// -------------------------------------------------------------
	// Queue bookkeeping, free of reset for battery backing
	// -------------------------------------------------------------
	// A field counts as occupied once fully written and free once fully
	// read; single sequencer keeps concurrent callers serialised.
	always_ff @(posedge mclk) begin
		if (rst_n && st_q == S_IDLE && bus.req && bus.op == OP_INIT) begin
			for (int c = 0; c < NUM_CONN; c++) begin
				base_q[c] <= '0;
				head_q[c] <= CNT_ZERO;
				occ_q[c]  <= CNT_ZERO;
				resv_q[c] <= bus.init_count[c];
			end
			for (int c = 1; c < NUM_CONN; c++) begin
				base_q[c] <= FIELD_W'(base_q_sum(c));
			end
			init_ok_q <= 1'b1;
		end else if (rst_n && st_q == S_WRITE && bus.wr_valid &&
			cnt_q + 6'h01 == flen_q[fld_q]) begin
			occ_q[conn_q] <= occ_q[conn_q] + 6'h01;
		end else if (rst_n && st_q == S_READ &&
			cnt_q + 6'h01 == flen_q[fld_q]) begin
			occ_q[conn_q] <= occ_q[conn_q] - 6'h01;
			if (head_q[conn_q] + 6'h01 == resv_q[conn_q]) begin
				head_q[conn_q] <= CNT_ZERO;
			end else begin
				head_q[conn_q] <= head_q[conn_q] + 6'h01;
			end
		end
	end

	// Running sum of reservations ahead of a connection gives its base.
	function automatic logic [CNT_W+CONN_W-1:0] base_q_sum(input int c);
		logic [CNT_W+CONN_W-1:0] s;
		s = '0;
		for (int k = 0; k < NUM_CONN; k++) begin
			if (k < c) begin
				s = s + (CNT_W+CONN_W)'(bus.init_count[k]);
			end
		end
		base_q_sum = s;
	endfunction : base_q_sum
	// Data kept across power loss is not cleared here.
endmodule : block_queue_buffer
`default_nettype wire

// file: logic/block_queue_cpu.sv
// Processor end: issues one command per user request and streams words.
`timescale 1ns/1ps
`default_nettype none
module block_queue_cpu (
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	block_queue_if.cpu                  bus,
	input  wire logic                   u_req,
	input  wire block_queue_pkg::op_t   u_op,
	input  wire logic [2:0]             u_own,
	input  wire logic [2:0]             u_peer,
	input  wire logic [5:0]             u_init [16],
	input  wire logic [4:0]             u_first,
	input  wire logic [5:0]             u_len,
	input  wire logic [15:0]            u_id,
	input  wire logic [15:0]            u_wdata,
	input  wire logic                   u_warm,
	output var  logic                   u_wtake,
	output var  logic                   u_done,
	output var  block_queue_pkg::status_t u_status,
	output var  logic [5:0]             u_cap
);
	import block_queue_pkg::*;

	logic              active_q;
	logic [5:0]        wcnt_q;
	logic              take;

	// A word is taken on each edge while the field still lacks words; the
	// count stops the stream at the block length so no spare word leaks.
	assign take = bus.busy && bus.op == OP_SEND && !bus.done &&
		wcnt_q != bus.length;

	// -------------------------------------------------------------
	// Request driver
	// -------------------------------------------------------------
	// One call moves one block; further blocks need further calls.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus.req  <= 1'b0;
			bus.op   <= OP_NONE;
			bus.own_cpu <= '0;
			bus.peer_cpu <= '0;
			bus.first_word <= '0;
			bus.length <= '0;
			bus.block_id <= 16'h0000;
			active_q <= 1'b0;
			for (int c = 0; c < NUM_CONN; c++) begin
				bus.init_count[c] <= CNT_ZERO;
			end
		end else begin
			bus.req <= 1'b0;
			if (!active_q && u_req && !bus.busy &&
				(u_op == OP_INIT ? !u_warm : bus.ready)) begin
				bus.req <= 1'b1;
				bus.op  <= u_op;
				bus.own_cpu <= u_own;
				bus.peer_cpu <= u_peer;
				bus.first_word <= u_first;
				bus.length <= u_len;
				bus.block_id <= u_id;
				bus.init_count <= u_init;
				active_q <= 1'b1;
			end else if (active_q && !u_req && !bus.req && !bus.busy) begin
				// A held request is served once; it must drop first.
				active_q <= 1'b0;
			end
		end
	end

	// Write words move while the buffer is filling a field.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			bus.wr_data  <= 16'h0000;
			bus.wr_valid <= 1'b0;
			wcnt_q   <= '0;
			u_wtake <= 1'b0;
			u_done  <= 1'b0;
			u_status <= ST_OK;
			u_cap   <= '0;
		end else begin
			bus.wr_valid <= take;
			bus.wr_data  <= u_wdata;
			u_wtake <= take;
			if (bus.req) begin
				wcnt_q <= '0;
			end else if (take) begin
				wcnt_q <= wcnt_q + 6'h01;
			end
			u_done  <= bus.done;
			if (bus.done) begin
				u_status <= bus.status;
				u_cap    <= bus.capacity;
			end
		end
	end
endmodule : block_queue_cpu
`default_nettype wire

// file: bench/block_queue_asserts.sv
// Checker for the signals between the processor end and the buffer end.
`timescale 1ns/1ps
`default_nettype none
module block_queue_asserts (
	input wire logic                              mclk,
	input wire logic                              rst_n,
	input wire logic                              req,
	input wire block_queue_pkg::op_t              op,
	input wire logic [block_queue_pkg::WORD_W:0]  length,
	input wire logic                              busy,
	input wire logic                              done,
	input wire block_queue_pkg::status_t          status,
	input wire logic [block_queue_pkg::CNT_W-1:0] capacity,
	input wire logic                              wr_valid,
	input wire logic                              rd_valid,
	input wire logic [block_queue_pkg::WORD_W:0]  rd_length
);
	import block_queue_pkg::*;
	logic [6:0] wn_q;
	logic [6:0] rn_q;

	// Words moved since the last request; a refused command moves none.
	always_ff @(posedge mclk) begin
		if (!rst_n || req) begin
			wn_q <= 7'h00;
			rn_q <= 7'h00;
		end else begin
			wn_q <= wn_q + 7'(wr_valid);
			rn_q <= rn_q + 7'(rd_valid);
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_test;
		req && (op == OP_SEND_TEST || op == OP_RECV_TEST);
	endsequence
	sequence s_ans;
		##1 done;
	endsequence

	test_answer_a: assert property (s_test |-> s_ans)
		else $error("capacity test not answered in one cycle");
	done_pulse_a: assert property (done |=> !done)
		else $error("done held longer than one cycle");
	req_idle_a: assert property (req |-> !busy)
		else $error("request issued while busy");
	status_hold_a: assert property (!done |-> $stable(status))
		else $error("status changed without done");
	cap_hold_a: assert property (!done |-> $stable(capacity))
		else $error("capacity changed without done");
	cap_bound_a: assert property (done |-> capacity <= NUM_FIELDS)
		else $error("capacity above field count");
	send_words_a: assert property (done && op == OP_SEND &&
		status == ST_OK |-> wn_q == 7'(length))
		else $error("send moved wrong word count");
	// The last read word arrives together with done.
	recv_words_a: assert property (done && op == OP_RECV &&
		status == ST_OK |-> rn_q + 7'(rd_valid) == 7'(rd_length))
		else $error("receive moved wrong word count");
	warn_quiet_a: assert property (done && status == ST_WARN
		|-> wn_q == 7'h00 && rn_q == 7'h00)
		else $error("refused command moved words");
	rd_op_a: assert property (rd_valid |-> op == OP_RECV)
		else $error("read word outside receive");
endmodule : block_queue_asserts
`default_nettype wire

// file: bench/test_multi_cpu_block_queue.sv
// Self-checking bench joining the processor end to the shared buffer.
`timescale 1ns/1ps
`default_nettype none
module test_multi_cpu_block_queue;
	import block_queue_pkg::*;
	logic        mclk;
	logic        rst_n;
	logic        u_req;
	op_t         u_op;
	logic [2:0]  u_own;
	logic [2:0]  u_peer;
	logic [5:0]  u_init [16];
	logic [4:0]  u_first;
	logic [5:0]  u_len;
	logic [15:0] u_id;
	logic [15:0] u_wdata;
	logic        u_warm;
	logic        u_wtake;
	logic        u_done;
	status_t     u_status;
	logic [5:0]  u_cap;
	logic [15:0] k;
	int          bad_count;
	int          n_checks;
	int          cyc;

	block_queue_if bus ();
	block_queue_buffer block_queue_buffer_i (.mclk, .rst_n, .bus(bus));
	block_queue_cpu block_queue_cpu_i (.mclk, .rst_n, .bus(bus), .u_req,
		.u_op, .u_own, .u_peer, .u_init, .u_first, .u_len, .u_id, .u_wdata,
		.u_warm, .u_wtake, .u_done, .u_status, .u_cap);
	block_queue_asserts block_queue_asserts_i (.mclk, .rst_n,
		.req(bus.req), .op(bus.op), .length(bus.length), .busy(bus.busy),
		.done(bus.done), .status(bus.status), .capacity(bus.capacity),
		.wr_valid(bus.wr_valid), .rd_valid(bus.rd_valid),
		.rd_length(bus.rd_length));

	// Free-running clock at 250 MHz.
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// A hang ends the run as a mismatch instead of stalling it.
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One command; the block length comes from the low id bits.
	task automatic cmd(op_t o, logic [2:0] tx, logic [2:0] rx,
		logic [15:0] id, status_t es, logic [5:0] ec);
		logic       r;
		logic [5:0] n;
		logic [5:0] w;
		r = (o == OP_RECV || o == OP_RECV_TEST);
		n = 6'(id[4:0]) + 6'h01;
		k = 16'h0000;
		w = 6'h00;
		u_op    <= o;
		u_own   <= r ? rx : tx;
		u_peer  <= r ? tx : rx;
		u_len   <= n;
		u_first <= 5'(6'h20 - n);
		u_id    <= id;
		u_wdata <= id;
		u_req   <= 1'b1;
		do begin
			@(posedge mclk);
			// The next word must stand before the edge that takes it.
			if (o == OP_SEND && bus.busy === 1'b1 && k < 16'(n)) begin
				k = k + 16'h0001;
				u_wdata <= id + k;
			end
			if (u_wtake === 1'b1) w = w + 6'h01;
			if (bus.rd_valid === 1'b1) begin
				chk("rd_data", id + k, bus.rd_data);
				k = k + 16'h0001;
			end
		end while (u_done !== 1'b1);
		u_req <= 1'b0;
		chk("status", {14'h0000, es}, {14'h0000, u_status});
		chk("wtake", {10'h000, (o == OP_SEND && es == ST_OK) ? n : 6'h00},
			{10'h000, w});
		if (o != OP_INIT) chk("cap", {10'h000, ec}, {10'h000, u_cap});
		if (o == OP_RECV && es == ST_OK) begin
			chk("block_id", id, bus.rd_block_id);
			chk("first", {11'h000, 5'(6'h20 - n)},
				{11'h000, bus.rd_first_word});
			chk("words", {10'h000, n}, k);
		end
		@(posedge mclk);
	endtask : cmd

	task automatic snd(logic [15:0] id, status_t es, logic [5:0] ec);
		cmd(OP_SEND, 3'h3, 3'h2, id, es, ec);
	endtask : snd

	task automatic rcv(logic [15:0] id, status_t es, logic [5:0] ec);
		cmd(OP_RECV, 3'h3, 3'h2, id, es, ec);
	endtask : rcv

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_init();
		u_init[9] <= 6'h07;
		u_init[6] <= 6'h02;
		cmd(OP_INIT, 3'h1, 3'h1, 16'h0000, ST_OK, 6'h00);
		chk("ready", 16'h0001, {15'h0000, bus.ready});
		cmd(OP_SEND_TEST, 3'h3, 3'h2, 16'h0000, ST_OK, 6'h07);
		cmd(OP_RECV_TEST, 3'h3, 3'h2, 16'h0000, ST_OK, 6'h00);
		cmd(OP_SEND_TEST, 3'h2, 3'h3, 16'h0000, ST_OK, 6'h02);
		cmd(OP_SEND_TEST, 3'h4, 3'h1, 16'h0000, ST_OK, 6'h00);
	endtask : t_init

	task automatic t_fifo();
		snd(16'h0A00, ST_OK, 6'h06);
		snd(16'h0B1F, ST_OK, 6'h05);
		snd(16'h0C04, ST_OK, 6'h04);
		cmd(OP_SEND, 3'h2, 3'h3, 16'h0D02, ST_OK, 6'h01);
		cmd(OP_RECV_TEST, 3'h3, 3'h2, 16'h0000, ST_OK, 6'h03);
		rcv(16'h0A00, ST_OK, 6'h02);
		rcv(16'h0B1F, ST_OK, 6'h01);
		rcv(16'h0C04, ST_OK, 6'h00);
		rcv(16'h0000, ST_WARN, 6'h00);
	endtask : t_fifo

	task automatic t_full();
		for (int i = 0; i < 7; i++) snd(16'h1000 + 16'(i), ST_OK, 6'(6 - i));
		snd(16'h1100, ST_WARN, 6'h00);
		cmd(OP_RECV_TEST, 3'h3, 3'h2, 16'h0000, ST_OK, 6'h07);
		rcv(16'h1000, ST_OK, 6'h06);
		snd(16'h1007, ST_OK, 6'h00);
		for (int i = 1; i < 8; i++) rcv(16'h1000 + 16'(i), ST_OK, 6'(7 - i));
	endtask : t_full

	// Warm restart keeps the queue; only a cold one initialises.
	task automatic t_restart();
		snd(16'h2003, ST_OK, 6'h06);
		u_warm <= 1'b1;
		rst_n  <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// An initialise asked for during warm restart must not be issued.
		u_op  <= OP_INIT;
		u_req <= 1'b1;
		repeat (3) @(posedge mclk);
		u_req <= 1'b0;
		@(posedge mclk);
		cmd(OP_RECV_TEST, 3'h3, 3'h2, 16'h0000, ST_OK, 6'h01);
		rcv(16'h2003, ST_OK, 6'h00);
		snd(16'h2101, ST_OK, 6'h06);
		u_warm <= 1'b0;
		cmd(OP_INIT, 3'h1, 3'h1, 16'h0000, ST_OK, 6'h00);
		cmd(OP_RECV_TEST, 3'h3, 3'h2, 16'h0000, ST_OK, 6'h00);
	endtask : t_restart

	// Main sequence.
	initial begin
		bad_count = 0;
		n_checks  = 0;
		cyc       = 0;
		rst_n     = 1'b0;
		u_req     = 1'b0;
		u_op      = OP_NONE;
		u_own     = 3'h1;
		u_peer    = 3'h1;
		u_first   = 5'h00;
		u_len     = 6'h01;
		u_id      = 16'h0000;
		u_wdata   = 16'h0000;
		u_warm    = 1'b0;
		for (int i = 0; i < 16; i++) u_init[i] = 6'h00;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		t_init();
		t_fifo();
		t_full();
		t_restart();
		finish_test();
	end
endmodule : test_multi_cpu_block_queue
`default_nettype wire
